// ===== rtl/load_store_multiple_stack_unit.sv
// Overview of operation
// [RULE1] Literal load reads one word at aligned counter plus offset into target register.
// [RULE2] Software keeps literal word aligned and within 1020 bytes of the counter.
// [RULE3] None of these operations alter the N, Z, C, V flags.
// [RULE4] Load-multiple fills each listed register from memory based on the base register.
// [RULE5] Store-multiple writes each listed register to memory based on the base register.
// [RULE6] Transfers use consecutive words, base up to base plus 4*(n-1).
// [RULE7] Registers go in ascending order, lowest register at lowest address.
// [RULE8] With writeback, base register becomes original base plus 4*n.
// [RULE9] Software limits base and list of multiple transfers to R0-R7.
// [RULE10] Software always asks writeback, except load-multiple listing its own base.
// [RULE11] Software supplies a word aligned base for multiple transfers.
// [RULE12] A stored base register must be lowest in the list, else value unpredictable.
// [RULE13] Software never issues an empty register list.
// [RULE14] Push and pop place lowest register at lowest stack address.
// [RULE15] Push writes its highest word at stack pointer minus four.
// [RULE16] Pop reads its lowest word at the current stack pointer.
// [RULE17] Push leaves pointer at lowest word; pop leaves it above highest word.
// [RULE18] Pop with counter branches to loaded value; bit 0 sets the state bit.
// [RULE19] Software limits stack lists to R0-R7, plus link for push, counter for pop.
// [RULE20] Signed halfword load sign-extends the 16-bit value to 32 bits.
// [RULE21] Each listed register moves as one single 32-bit word access.
`include "lsm_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module load_store_multiple_stack_unit
    import lsm_pkg::*;
(
    // Clock and reset
    input  wire logic                      CORE_CLK,
    input  wire logic                      RESET_N,
    // Command from the core
    input  wire logic                      CMD_VALID,
    input  wire logic [2:0]                CMD_OP,
    input  wire logic [2:0]                CMD_TARGET,
    input  wire logic [2:0]                CMD_BASE,
    input  wire logic [2:0]                CMD_OFFSET_REG,
    input  wire logic [7:0]                CMD_LIST,
    input  wire logic                      CMD_EXTRA,
    input  wire logic                      CMD_WRITEBACK,
    input  wire logic [`LSM_IMM_W-1:0]     CMD_IMM,
    output logic                           CMD_READY,
    output logic                           CMD_DONE,
    // Register file access from the core while idle
    input  wire logic                      REG_WE,
    input  wire logic [3:0]                REG_WSEL,
    input  wire logic [31:0]               REG_WDATA,
    input  wire logic [3:0]                REG_RSEL,
    output logic [31:0]                    REG_RDATA,
    input  wire logic                      FLAG_WE,
    input  wire logic [3:0]                FLAG_WDATA,
    output logic [3:0]                     FLAGS,
    output logic                           TBIT,
    // Data bus to system memory
    output logic                           MEM_REQ,
    output logic                           MEM_WE,
    output logic                           MEM_SIZE,
    output logic [31:0]                    MEM_ADDR,
    output logic [31:0]                    MEM_WDATA,
    input  wire logic                      MEM_ACK,
    input  wire logic [31:0]               MEM_RDATA
);

    //**********************************************************
    // Helpers
    //**********************************************************

    // Index of the lowest set bit of a one-hot low-register mask
    function automatic logic [3:0] enc_low(input logic [7:0] onehot);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 0; i < 8; i++)
            if (onehot[i])
                idx = 4'(i);
        return idx;
    endfunction : enc_low

    //**********************************************************
    // State
    //**********************************************************

    lsm_state_t                state;
    lsm_op_t                   op;
    logic [31:0]               regs [0:15];
    logic [`LSM_LIST_W-1:0]    pend;
    logic [3:0]                count;
    logic [31:0]               start_addr;
    logic [2:0]                rt;
    logic [2:0]                rn;
    logic                      wb;
    logic [31:0]               pc_word;
    logic                      pop_pc;

    //**********************************************************
    // Decode and selection
    //**********************************************************

    // Command fields and transfer list of the incoming command
    wire lsm_op_t                cmd_op     = lsm_op_t'(CMD_OP);
    wire logic                   cmd_legal  = CMD_OP <= 3'h5;
    wire logic                   cmd_multi  = (cmd_op == OP_LOAD_MULTIPLE) || (cmd_op == OP_STORE_MULTIPLE)
                                              || (cmd_op == OP_PUSH) || (cmd_op == OP_POP);
    wire logic [`LSM_LIST_W-1:0] cmd_mask   = cmd_multi ? {CMD_EXTRA & ((cmd_op == OP_PUSH) || (cmd_op == OP_POP)),
                                                           CMD_LIST} : 9'h001;
    wire logic                   accept     = (state == ST_IDLE) && CMD_VALID && cmd_legal;

    // Number of registers in the list
    logic [3:0] cmd_count;
    always_comb
    begin
        cmd_count = 4'h0;
        for (int i = 0; i < `LSM_LIST_W; i++)
            cmd_count = cmd_count + {3'h0, cmd_mask[i]};
    end

    // Bytes spanned by the list: 4*n
    wire logic [31:0] cmd_span   = {26'h0, cmd_count, 2'b00};
    wire logic [31:0] base_val   = regs[{1'b0, CMD_BASE}];
    wire logic [31:0] sp_val     = regs[`LSM_SP_IDX];
    wire logic [31:0] lit_addr   = {regs[`LSM_PC_IDX][31:2], 2'b00} + {22'h0, CMD_IMM, 2'b00};  // RULE1
    wire logic [31:0] half_addr  = regs[{1'b0, CMD_BASE}] + regs[{1'b0, CMD_OFFSET_REG}];

    // First address: push starts 4*n below the pointer so its top word lands at SP-4
    logic [31:0] cmd_addr;
    always_comb
    begin
        case (cmd_op)
            OP_LOAD_WORD_LIT:    cmd_addr = lit_addr;
            OP_PUSH:             cmd_addr = sp_val - cmd_span;  // RULE15
            OP_POP:              cmd_addr = sp_val;             // RULE16
            OP_LOAD_SIGNED_HALF: cmd_addr = half_addr;
            default:             cmd_addr = base_val;           // RULE4 RULE5
        endcase
    end

    // Lowest pending slot goes next, so order is ascending by register
    wire logic [`LSM_LIST_W-1:0] low_pend  = pend & (~pend + 9'h001);  // RULE7 RULE14
    wire logic [`LSM_LIST_W-1:0] rest      = pend & ~low_pend;
    wire logic [`LSM_LIST_W-1:0] low_rest  = rest & (~rest + 9'h001);
    wire logic [`LSM_LIST_W-1:0] low_cmd   = cmd_mask & (~cmd_mask + 9'h001);
    wire logic [3:0]             extra_idx = (op == OP_PUSH) ? `LSM_LR_IDX : `LSM_PC_IDX;
    wire logic [3:0]             cur_idx   = low_pend[`LSM_EXTRA_BIT] ? extra_idx : enc_low(low_pend[7:0]);
    wire logic [3:0]             rest_idx  = low_rest[`LSM_EXTRA_BIT] ? `LSM_LR_IDX : enc_low(low_rest[7:0]);
    wire logic [3:0]             cmd_idx   = low_cmd[`LSM_EXTRA_BIT] ? `LSM_LR_IDX : enc_low(low_cmd[7:0]);

    // Access kind of the incoming and captured command, and beat status
    wire logic cmd_store = (cmd_op == OP_STORE_MULTIPLE) || (cmd_op == OP_PUSH);
    wire logic is_store  = (op == OP_STORE_MULTIPLE) || (op == OP_PUSH);
    wire logic beat_done = (state == ST_XFER) && MEM_ACK;
    wire logic last_beat = beat_done && (rest == 9'h000);

    // Selected halfword lane, little endian, sign-extended
    wire logic [15:0] half_lane = MEM_ADDR[1] ? MEM_RDATA[31:16] : MEM_RDATA[15:0];
    wire logic [31:0] half_sext = {{16{half_lane[15]}}, half_lane};  // RULE20

    //**********************************************************
    // Sequencer
    //**********************************************************

    // Empty list skips the bus; it is illegal code but must not hang the core
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            state <= ST_IDLE;
        else if (accept)
            state <= (cmd_count == 4'h0) ? ST_FINISH : ST_XFER;
        else if (last_beat || state == ST_FINISH)
            state <= (state == ST_FINISH) ? ST_IDLE : ST_FINISH;
    end

    // Captured command
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            op         <= OP_LOAD_WORD_LIT;
            rt         <= 3'h0;
            rn         <= 3'h0;
            wb         <= 1'b0;
            count      <= 4'h0;
            start_addr <= `LSM_RESET_WORD;
            pop_pc     <= 1'b0;
        end
        else if (accept)
        begin
            op         <= cmd_op;
            rt         <= CMD_TARGET;
            rn         <= CMD_BASE;
            wb         <= CMD_WRITEBACK;
            count      <= cmd_count;
            start_addr <= cmd_addr;
            pop_pc     <= (cmd_op == OP_POP) && CMD_EXTRA;
        end
    end

    // Pending list shrinks by its lowest slot on each acknowledged beat
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            pend <= 9'h000;
        else if (accept)
            pend <= cmd_mask;
        else if (beat_done)
            pend <= rest;
    end

    //**********************************************************
    // Data bus
    //**********************************************************

    // Request held until acknowledged; one word per listed register
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            MEM_REQ   <= 1'b0;
            MEM_WE    <= 1'b0;
            MEM_SIZE  <= SIZE_WORD;
            MEM_ADDR  <= `LSM_RESET_WORD;
            MEM_WDATA <= `LSM_RESET_WORD;
        end
        else if (accept && cmd_count != 4'h0)
        begin
            MEM_REQ   <= 1'b1;
            MEM_WE    <= cmd_store;
            MEM_SIZE  <= (cmd_op == OP_LOAD_SIGNED_HALF) ? SIZE_HALF : SIZE_WORD;  // RULE21
            MEM_ADDR  <= cmd_addr;
            MEM_WDATA <= cmd_store ? regs[cmd_idx] : `LSM_RESET_WORD;
        end
        else if (beat_done)
        begin
            MEM_REQ   <= !last_beat;
            MEM_ADDR  <= MEM_ADDR + 32'h4;  // RULE6
            MEM_WDATA <= is_store ? regs[rest_idx] : `LSM_RESET_WORD;  // RULE5
        end
    end

    //**********************************************************
    // Register file
    //**********************************************************

    // Loads land on the beat; base and pointer updates after the last beat
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            for (int i = 0; i < 16; i++)
                regs[i] <= `LSM_RESET_WORD;
            pc_word <= `LSM_RESET_WORD;
            TBIT    <= `LSM_RESET_TBIT;
        end
        else if (beat_done && !is_store)
        begin
            if (op == OP_LOAD_WORD_LIT)
                regs[{1'b0, rt}] <= MEM_RDATA;  // RULE1
            else if (op == OP_LOAD_SIGNED_HALF)
                regs[{1'b0, rt}] <= half_sext;  // RULE20
            else if (low_pend[`LSM_EXTRA_BIT])
                pc_word <= MEM_RDATA;
            else
                regs[cur_idx] <= MEM_RDATA;     // RULE4
        end
        else if (state == ST_FINISH)
        begin
            if ((op == OP_LOAD_MULTIPLE || op == OP_STORE_MULTIPLE) && wb)
                regs[{1'b0, rn}] <= start_addr + {26'h0, count, 2'b00};  // RULE8
            if (op == OP_PUSH)
                regs[`LSM_SP_IDX] <= start_addr;  // RULE17
            if (op == OP_POP)
                regs[`LSM_SP_IDX] <= start_addr + {26'h0, count, 2'b00};  // RULE17
            if (pop_pc)
            begin
                regs[`LSM_PC_IDX] <= {pc_word[31:1], 1'b0};  // RULE18
                TBIT              <= pc_word[0];
            end
        end
        else if (state == ST_IDLE && REG_WE)
            regs[REG_WSEL] <= REG_WDATA;
    end

    // Flags only change by the core's own write while idle
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            FLAGS <= `LSM_RESET_FLAGS;
        else if (state == ST_IDLE && FLAG_WE && !accept)
            FLAGS <= FLAG_WDATA;  // RULE3
    end

    // Handshake and read port
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            CMD_READY <= 1'b0;
            CMD_DONE  <= 1'b0;
            REG_RDATA <= `LSM_RESET_WORD;
        end
        else
        begin
            CMD_READY <= (state == ST_FINISH) || (state == ST_IDLE && !accept);
            CMD_DONE  <= (state == ST_FINISH);
            REG_RDATA <= regs[REG_RSEL];
        end
    end

    //**********************************************************
    // Assertions
    //**********************************************************

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);

    sequence s_next_beat;
        beat_done && !last_beat;
    endsequence

    sequence s_finish;
        state == ST_FINISH;
    endsequence

    a_flags_busy:   assert property ((state != ST_IDLE) |=> $stable(FLAGS))  // RULE3
        else $error("flags changed during a transfer");
    a_word_access:  assert property (MEM_REQ && op != OP_LOAD_SIGNED_HALF |-> MEM_SIZE == SIZE_WORD)  // RULE21
        else $error("multiple transfer not a word access");
    a_addr_step:    assert property (s_next_beat |=> MEM_REQ && MEM_ADDR == $past(MEM_ADDR) + 32'h4)  // RULE6
        else $error("transfer address not four above previous");
    a_order_up:     assert property (s_next_beat |=> cur_idx > $past(cur_idx) || op == OP_POP || op == OP_PUSH)  // RULE7
        else $error("registers not ascending");
    a_first_base:   assert property (accept && cmd_op == OP_LOAD_MULTIPLE && cmd_count != 4'h0
                                     |=> MEM_ADDR == $past(base_val))  // RULE4
        else $error("load multiple did not start at base");
    a_store_data:   assert property (MEM_REQ && op == OP_STORE_MULTIPLE |-> MEM_WE && MEM_WDATA == regs[cur_idx])  // RULE5
        else $error("store multiple data mismatch");
    a_push_top:     assert property (MEM_REQ && op == OP_PUSH && rest == 9'h000
                                     |-> MEM_ADDR == regs[`LSM_SP_IDX] - 32'h4)  // RULE15
        else $error("push top word not at pointer minus four");
    a_pop_start:    assert property (accept && cmd_op == OP_POP && cmd_count != 4'h0
                                     |=> MEM_ADDR == $past(sp_val))  // RULE16
        else $error("pop did not start at pointer");
    a_base_wback:   assert property (s_finish ##0 (op == OP_STORE_MULTIPLE && wb)
                                     |=> regs[{1'b0, rn}] == $past(start_addr) + {26'h0, $past(count), 2'b00})  // RULE8
        else $error("base writeback wrong");
    a_push_sp:      assert property (s_finish ##0 (op == OP_PUSH) |=> regs[`LSM_SP_IDX] == $past(start_addr))  // RULE17
        else $error("push pointer not at lowest word");
    a_pop_branch:   assert property (s_finish ##0 pop_pc
                                     |=> TBIT == $past(pc_word[0]) && regs[`LSM_PC_IDX][31:1] == $past(pc_word[31:1]))  // RULE18
        else $error("pop branch target wrong");
    a_half_sext:    assert property (beat_done && op == OP_LOAD_SIGNED_HALF
                                     |=> regs[{1'b0, rt}] == {{16{$past(half_lane[15])}}, $past(half_lane)})  // RULE20
        else $error("halfword not sign extended");
    a_literal_rd:   assert property (beat_done && op == OP_LOAD_WORD_LIT
                                     |-> !MEM_WE && MEM_ADDR[1:0] == 2'b00 ##1 regs[{1'b0, rt}] == $past(MEM_RDATA))  // RULE1
        else $error("literal load wrong");

endmodule : load_store_multiple_stack_unit

`default_nettype wire

// ===== rtl/lsm_defs.svh
`ifndef LSM_DEFS_SVH
`define LSM_DEFS_SVH

// Register file indexes for the special registers
`define LSM_SP_IDX      4'hd
`define LSM_LR_IDX      4'he
`define LSM_PC_IDX      4'hf

// Transfer list: bits 7..0 low registers, bit 8 link or counter slot
`define LSM_LIST_W      9
`define LSM_EXTRA_BIT   8

// Reset values
`define LSM_RESET_WORD  32'h0000_0000
`define LSM_RESET_FLAGS 4'h0
`define LSM_RESET_TBIT  1'b1

// Literal loads reach up to 255 words (1020 bytes) past the aligned counter
`define LSM_IMM_W       8

`endif

// ===== rtl/lsm_pkg.sv
package lsm_pkg;

    // Operations taken on the command port
    typedef enum logic [2:0] {
        OP_LOAD_WORD_LIT   = 3'h0,  // load_word_op, counter relative
        OP_LOAD_MULTIPLE   = 3'h1,  // load_multiple_op
        OP_STORE_MULTIPLE  = 3'h2,  // store_multiple_op
        OP_PUSH            = 3'h3,
        OP_POP             = 3'h4,
        OP_LOAD_SIGNED_HALF = 3'h5  // load_signed_halfword_op
    } lsm_op_t;

    // Sequencer states, Gray along idle -> transfer -> finish
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_XFER   = 2'h1,
        ST_FINISH = 2'h3
    } lsm_state_t;

    // Access size driven on the data bus
    typedef enum logic {
        SIZE_WORD = 1'h0,
        SIZE_HALF = 1'h1
    } lsm_size_t;

endpackage : lsm_pkg

// ===== tb/data_memory_model.sv
`timescale 1ns/1ns
`default_nettype none

// Word memory on the far side of the data bus
module data_memory_model
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Bus from the unit
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic        size,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    output logic             ack,
    output logic [31:0]      rdata,
    // Wait states before each acknowledge
    input  wire logic [1:0]  wait_cycles
);
    logic [31:0] words [64];
    logic [1:0]  cnt;

    // ****
    // Acknowledge after the chosen wait; data is only valid with ack
    // ****
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack   <= 1'b0;
            cnt   <= 2'h0;
            rdata <= 32'h0;
        end
        else if (req && !ack && cnt == wait_cycles)
        begin
            ack   <= 1'b1;
            cnt   <= 2'h0;
            rdata <= words[addr[7:2]]; // Halfword lane is picked by the unit
            if (we)
                words[addr[7:2]] <= wdata;
        end
        else
        begin
            ack   <= 1'b0;
            rdata <= ~rdata; // Stale data never looks like a match
            if (req && !ack)
                cnt <= cnt + 2'h1;
        end
    end
endmodule : data_memory_model

`default_nettype wire

// ===== tb/load_store_multiple_stack_unit_bench.sv
`timescale 1ns/1ns
`default_nettype none

module load_store_multiple_stack_unit_bench
    import lsm_pkg::*;
;
    logic        CORE_CLK, RESET_N, CMD_VALID, CMD_EXTRA, CMD_WRITEBACK, REG_WE, FLAG_WE;
    logic [2:0]  CMD_OP, CMD_TARGET, CMD_BASE, CMD_OFFSET_REG;
    logic [7:0]  CMD_LIST, CMD_IMM;
    logic [3:0]  REG_WSEL, REG_RSEL, FLAG_WDATA, FLAGS;
    logic [31:0] REG_WDATA, REG_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, v;
    logic        CMD_READY, CMD_DONE, TBIT, MEM_REQ, MEM_WE, MEM_SIZE, MEM_ACK;
    logic [1:0]  wait_cycles;
    int          errors, checks, cycles;

    load_store_multiple_stack_unit dut (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CMD_VALID(CMD_VALID),
        .CMD_OP(CMD_OP), .CMD_TARGET(CMD_TARGET), .CMD_BASE(CMD_BASE), .CMD_OFFSET_REG(CMD_OFFSET_REG),
        .CMD_LIST(CMD_LIST), .CMD_EXTRA(CMD_EXTRA), .CMD_WRITEBACK(CMD_WRITEBACK), .CMD_IMM(CMD_IMM),
        .CMD_READY(CMD_READY), .CMD_DONE(CMD_DONE), .REG_WE(REG_WE), .REG_WSEL(REG_WSEL),
        .REG_WDATA(REG_WDATA), .REG_RSEL(REG_RSEL), .REG_RDATA(REG_RDATA), .FLAG_WE(FLAG_WE),
        .FLAG_WDATA(FLAG_WDATA), .FLAGS(FLAGS), .TBIT(TBIT), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
        .MEM_SIZE(MEM_SIZE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
        .MEM_RDATA(MEM_RDATA));

    data_memory_model mem (.clk(CORE_CLK), .rst_n(RESET_N), .req(MEM_REQ), .we(MEM_WE), .size(MEM_SIZE),
        .addr(MEM_ADDR), .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA), .wait_cycles(wait_cycles));

    // ****
    // Clock and hang guard
    // ****
    always #5 CORE_CLK = ~CORE_CLK;

    always @(posedge CORE_CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            $display("ERROR %0t run did not finish", $time);
            report_and_stop();
        end
    end

    // ****
    // Shared tasks
    // ****
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : check_word

    task automatic set_reg(input logic [3:0] idx, input logic [31:0] val);
        @(negedge CORE_CLK);
        REG_WE = 1'b1;
        REG_WSEL = idx;
        REG_WDATA = val;
        @(negedge CORE_CLK);
        REG_WE = 1'b0;
    endtask : set_reg

    // Read port answers one cycle after the select
    task automatic get_reg(input logic [3:0] idx, output logic [31:0] val);
        @(negedge CORE_CLK);
        REG_RSEL = idx;
        @(negedge CORE_CLK);
        val = REG_RDATA;
    endtask : get_reg

    task automatic run_cmd(input lsm_op_t op, input logic [2:0] tgt, input logic [2:0] base,
                           input logic [2:0] offr, input logic [7:0] list, input logic [7:0] imm,
                           input logic extra, input logic wb);
        int n;
        n = 0;
        @(negedge CORE_CLK);
        CMD_OP = op;
        CMD_TARGET = tgt;
        CMD_BASE = base;
        CMD_OFFSET_REG = offr;
        CMD_LIST = list;
        CMD_IMM = imm;
        CMD_EXTRA = extra;
        CMD_WRITEBACK = wb;
        CMD_VALID = 1'b1;
        while (CMD_READY !== 1'b1 && n < 50)
        begin
            @(negedge CORE_CLK);
            n++;
        end
        @(negedge CORE_CLK);
        CMD_VALID = 1'b0;
        while (CMD_DONE !== 1'b1 && n < 100)
        begin
            @(negedge CORE_CLK);
            n++;
        end
        check_word({31'h0, CMD_DONE}, 32'h1, "command completion");
        check_word({28'h0, FLAGS}, 32'ha, "flags kept");
    endtask : run_cmd

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // ****
    // Scenarios
    // ****
    task automatic t_literal;
        set_reg(4'hf, 32'h13); // Low bits of the counter are ignored
        mem.words[7] = 32'hcafe_0001;
        run_cmd(OP_LOAD_WORD_LIT, 3'h2, 3'h0, 3'h0, 8'h00, 8'h03, 1'b0, 1'b0);
        get_reg(4'h2, v);
        check_word(v, 32'hcafe_0001, "literal word");
        $display("literal load test done");
    endtask : t_literal

    // Slow memory, scattered list, writeback
    task automatic t_store_multiple;
        wait_cycles = 2'h2;
        mem.words[19] = 32'h5a5a_5a5a;
        set_reg(4'h0, 32'h40);
        set_reg(4'h1, 32'h1111_1111);
        set_reg(4'h3, 32'h3333_3333);
        set_reg(4'h6, 32'h6666_6666);
        run_cmd(OP_STORE_MULTIPLE, 3'h0, 3'h0, 3'h0, 8'h4a, 8'h00, 1'b0, 1'b1);
        check_word(mem.words[16], 32'h1111_1111, "store first");
        check_word(mem.words[17], 32'h3333_3333, "store second");
        check_word(mem.words[18], 32'h6666_6666, "store third");
        check_word(mem.words[19], 32'h5a5a_5a5a, "store past end");
        get_reg(4'h0, v);
        check_word(v, 32'h4c, "store writeback");
        $display("store multiple test done");
    endtask : t_store_multiple

    // Base in its own list, no writeback
    task automatic t_load_multiple;
        wait_cycles = 2'h0;
        mem.words[32] = 32'ha000_0000;
        mem.words[33] = 32'hb000_0005;
        mem.words[34] = 32'hc000_0007;
        set_reg(4'h5, 32'h80);
        run_cmd(OP_LOAD_MULTIPLE, 3'h0, 3'h5, 3'h0, 8'ha1, 8'h00, 1'b0, 1'b0);
        get_reg(4'h0, v);
        check_word(v, 32'ha000_0000, "load lowest");
        get_reg(4'h5, v);
        check_word(v, 32'hb000_0005, "load base");
        get_reg(4'h7, v);
        check_word(v, 32'hc000_0007, "load highest");
        $display("load multiple test done");
    endtask : t_load_multiple

    task automatic t_push;
        wait_cycles = 2'h1;
        set_reg(4'hd, 32'hc0);
        set_reg(4'h0, 32'h0a0a_0a0a);
        set_reg(4'h4, 32'h4444_0004);
        set_reg(4'he, 32'h0000_1235);
        run_cmd(OP_PUSH, 3'h0, 3'h0, 3'h0, 8'h11, 8'h00, 1'b1, 1'b0);
        check_word(mem.words[45], 32'h0a0a_0a0a, "push lowest");
        check_word(mem.words[46], 32'h4444_0004, "push middle");
        check_word(mem.words[47], 32'h0000_1235, "push link");
        get_reg(4'hd, v);
        check_word(v, 32'hb4, "push pointer");
        $display("push test done");
    endtask : t_push

    // Both values of the state bit, so it must really move
    task automatic t_pop;
        for (int t = 0; t < 2; t++)
        begin
            mem.words[52] = 32'h1000_0001 + t;
            mem.words[53] = 32'h2000_0002 + t;
            mem.words[54] = 32'h100 | t;
            set_reg(4'hd, 32'hd0);
            run_cmd(OP_POP, 3'h0, 3'h0, 3'h0, 8'h06, 8'h00, 1'b1, 1'b0);
            get_reg(4'h1, v);
            check_word(v, 32'h1000_0001 + t, "pop lowest");
            get_reg(4'h2, v);
            check_word(v, 32'h2000_0002 + t, "pop middle");
            get_reg(4'hd, v);
            check_word(v, 32'hdc, "pop pointer");
            get_reg(4'hf, v);
            check_word(v, 32'h100, "pop branch");
            check_word({31'h0, TBIT}, t, "state bit");
        end
        $display("pop test done");
    endtask : t_pop

    // Upper lane negative, lower lane positive
    task automatic t_half;
        mem.words[56] = 32'h8001_1234;
        set_reg(4'h2, 32'he0);
        for (int t = 0; t < 2; t++)
        begin
            set_reg(4'h3, 32'h2 - 2 * t);
            run_cmd(OP_LOAD_SIGNED_HALF, 3'h4, 3'h2, 3'h3, 8'h00, 8'h00, 1'b0, 1'b0);
            get_reg(4'h4, v);
            check_word(v, t ? 32'h0000_1234 : 32'hffff_8001, "signed half");
        end
        $display("signed halfword test done");
    endtask : t_half

    // ****
    // Main sequence
    // ****
    initial
    begin
        CORE_CLK = 1'b0;
        RESET_N = 1'b0;
        {CMD_VALID, CMD_EXTRA, CMD_WRITEBACK, REG_WE, FLAG_WE} = 5'h00;
        {CMD_OP, CMD_TARGET, CMD_BASE, CMD_OFFSET_REG} = 12'h000;
        {CMD_LIST, CMD_IMM, REG_WSEL, REG_RSEL, FLAG_WDATA} = 28'h0;
        REG_WDATA = 32'h0;
        wait_cycles = 2'h0;
        errors = 0;
        checks = 0;
        cycles = 0;
        repeat (2) @(negedge CORE_CLK);
        RESET_N = 1'b1;
        check_word({31'h0, TBIT}, 32'h1, "state bit after reset");
        @(negedge CORE_CLK);
        FLAG_WE = 1'b1;
        FLAG_WDATA = 4'ha;
        @(negedge CORE_CLK);
        FLAG_WE = 1'b0;
        t_literal();
        t_store_multiple();
        t_load_multiple();
        t_push();
        t_pop();
        t_half();
        report_and_stop();
    end
endmodule : load_store_multiple_stack_unit_bench

`default_nettype wire
